// [logic/codec_consts.vh]
// constants for the codec serial port and gain tap block
//
// Functional notes
// - analog tap coefficient is five low bits, 32 codes, step 0.0625
// - with analog tap powered, tap register holds coefficient, enable and mute
// - enable connects tap to summing node; mute forces zero gain
// - code 0 is +1.00, down to +0.0625, then -0.0625 to -1.00
// - modulator bit one adds digital tap, zero subtracts it
// - digital tap is sixteen bit twos complement, 0x8000 is -1.00
// - every link word is sixteen bits, msb first, one per serial clock
// - front end makes serial clock and frame timing, host is slave
// - operating mode bit zero: words are register access commands
// - operating mode one, mixed off: words are converter samples
// - mixed mode: top bit flags control or sample, fifteen bit samples
// - one shift register both ways, reloaded with input sample per event
// - two channels chained, input to channel one, output from channel two
// - each channel has eight rw control registers and two data registers
// - control register updates take effect on falling serial clock edge
// - master divider field bits four to six divides by one to five
// - serial bit rate is device clock divided by one, two, four or eight
// - serial rate limits words per sample period; host must not exceed it
// - serial clock select 00 is /8 default, 01 /4, 10 /2, 11 /1
// - sample rate select 00 /2048 default, 01 /1024, 10 /512, 11 /256
// - command word fields; chain address two or more decremented by two and forwarded
`ifndef CODEC_CONSTS_VH
`define CODEC_CONSTS_VH

`define REG_SERIAL_MODE  3'h0
`define REG_CLOCK_DIV    3'h1
`define REG_POWER        3'h2
`define REG_ANALOG_TAP   3'h5
`define REG_DTAP_UPPER   3'h6
`define REG_DTAP_LOWER   3'h7
`define REG_RESET_VALUE  8'h00

`define MODE_OP_BIT      0
`define MODE_MIXED_BIT   1
`define PWR_ATAP_BIT     1
`define ATAP_COEF_HI     4
`define ATAP_COEF_LO     0
`define ATAP_EN_BIT      5
`define ATAP_MUTE_BIT    7
`define ATAP_SIGN_BIT    4
`define CDIV_MCD_HI      6
`define CDIV_MCD_LO      4
`define CDIV_SCD_HI      3
`define CDIV_SCD_LO      2
`define CDIV_SR_HI       1
`define CDIV_SR_LO       0

`define WORD_CTL_BIT     15
`define WORD_RW_BIT      14
`define WORD_DEV_HI      13
`define WORD_DEV_LO      11
`define WORD_REG_HI      10
`define WORD_REG_LO      8
`define WORD_DATA_HI     7
`define WORD_DATA_LO     0
`define WORD_LAST_BIT    4'hF
`define DEVS_PER_PART    3'h2

`define SR_LAST_2048     12'h7FF
`define SR_LAST_1024     12'h3FF
`define SR_LAST_512      12'h1FF
`define SR_LAST_256      12'h0FF
`define SCLK_LAST_8      3'h7
`define SCLK_LAST_4      3'h3
`define SCLK_LAST_2      3'h1
`define SCLK_LAST_1      3'h0
`define ATAP_UNITY       6'h10
`define ATAP_NEG_BASE    6'h0F
`define FIFO_DEPTH_LOG   4

`endif

// [logic/codec_serial_port.v]
// codec front end serial port, clock dividers, control bank and gain taps
`timescale 1ns/1ns
`include "codec_consts.vh"

// ****************************************************************
// word fifo between the serial shifter and the register consumer
// ****************************************************************
module word_fifo #(
	parameter WIDTH = 17,
	parameter DEPTH_LOG = 4
) (
	input  wire             clk,
	input  wire             reset_n,
	input  wire             ce,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output reg  [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);
	localparam DEPTH = 1 << DEPTH_LOG;
	reg [WIDTH-1:0]   mem [0:DEPTH-1];
	reg [DEPTH_LOG:0] wrPtr_ff;
	reg [DEPTH_LOG:0] rdPtr_ff;
	wire              isEmpty;
	wire              isFull;
	wire              doPush;
	wire              doPop;

	assign isEmpty = (wrPtr_ff == rdPtr_ff);
	assign isFull = (wrPtr_ff[DEPTH_LOG] != rdPtr_ff[DEPTH_LOG]) &&
		(wrPtr_ff[DEPTH_LOG-1:0] == rdPtr_ff[DEPTH_LOG-1:0]);
	assign inReady = !isFull;
	assign outValid = !isEmpty;
	assign doPush = inValid && !isFull;
	assign doPop = outReady && !isEmpty;

	always @*
	begin
		outData = mem[rdPtr_ff[DEPTH_LOG-1:0]];
	end

	always @(posedge clk)
	begin
		if (ce && doPush)
			mem[wrPtr_ff[DEPTH_LOG-1:0]] <= inData;
	end

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wrPtr_ff <= {(DEPTH_LOG+1){1'b0}};
			rdPtr_ff <= {(DEPTH_LOG+1){1'b0}};
		end
		else if (ce)
		begin
			if (doPush)
				wrPtr_ff <= wrPtr_ff + 1'b1;
			if (doPop)
				rdPtr_ff <= rdPtr_ff + 1'b1;
		end
	end
endmodule // word_fifo

// ****************************************************************
// top: serial port of the dual front end, always frame master
// ****************************************************************
module codec_serial_port (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        ce,
	output reg         sclkOut,
	output reg         outFrameSync,
	output reg         sdoOut,
	input  wire        sdiIn,
	input  wire        inFrameSyncIn,
	input  wire [15:0] adcSample,
	input  wire [1:0]  modBit,
	input  wire [31:0] interpOut,
	output reg  [31:0] dacSample,
	output reg  [33:0] tapSum,
	output wire [11:0] analogTapGain,
	output wire [1:0]  analogTapConnect,
	output wire [1:0]  analogTapPowered,
	output reg         dmclkTick,
	output reg         sampleEvent,
	output wire        rxOverflow
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	reg  [2:0] sdiSync_ff;
	reg  [2:0] fsSync_ff;
	reg        sdiVal_ff;
	reg        fsVal_ff;

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sdiSync_ff <= 3'h0;
			fsSync_ff <= 3'h0;
			sdiVal_ff <= 1'b0;
			fsVal_ff <= 1'b0;
		end
		else if (ce)
		begin
			sdiSync_ff <= {sdiSync_ff[1:0], sdiIn};
			fsSync_ff <= {fsSync_ff[1:0], inFrameSyncIn};
			if (sdiSync_ff[1] == sdiSync_ff[2])
				sdiVal_ff <= sdiSync_ff[2];
			if (fsSync_ff[1] == fsSync_ff[2])
				fsVal_ff <= fsSync_ff[2];
		end
	end

	// ************************************************************
	// control bank: eight registers per channel, index {chan, addr}
	// ************************************************************
	reg  [7:0] ctlRegs [0:15];
	wire [7:0] modeReg;
	wire [7:0] divReg;
	wire       opMode;
	wire       mixedMode;

	// serial mode and divider come from channel one; host keeps both equal
	assign modeReg = ctlRegs[{1'b0, `REG_SERIAL_MODE}];
	assign divReg = ctlRegs[{1'b0, `REG_CLOCK_DIV}];
	assign opMode = modeReg[`MODE_OP_BIT];
	assign mixedMode = modeReg[`MODE_MIXED_BIT];

	// ************************************************************
	// master divider, serial clock and sample rate timing
	// ************************************************************
	reg  [2:0]  mcdCnt_ff;
	reg  [2:0]  mcdLast;
	reg  [2:0]  sclkCnt_ff;
	reg  [2:0]  sclkLast;
	reg  [11:0] srCnt_ff;
	reg  [11:0] srLast;
	wire        bitRise;
	wire        bitFall;
	wire        sampleTick;

	always @*
	begin
		case (divReg[`CDIV_MCD_HI:`CDIV_MCD_LO])
			3'h1: mcdLast = 3'h1;
			3'h2: mcdLast = 3'h2;
			3'h3: mcdLast = 3'h3;
			3'h4: mcdLast = 3'h4;
			default: mcdLast = 3'h0;
		endcase
		case (divReg[`CDIV_SCD_HI:`CDIV_SCD_LO])
			2'h0: sclkLast = `SCLK_LAST_8;
			2'h1: sclkLast = `SCLK_LAST_4;
			2'h2: sclkLast = `SCLK_LAST_2;
			default: sclkLast = `SCLK_LAST_1;
		endcase
		case (divReg[`CDIV_SR_HI:`CDIV_SR_LO])
			2'h0: srLast = `SR_LAST_2048;
			2'h1: srLast = `SR_LAST_1024;
			2'h2: srLast = `SR_LAST_512;
			default: srLast = `SR_LAST_256;
		endcase
	end

	// serial clock rises at the start of each bit period and falls midway;
	// at the undivided rate both land on one tick, so the pin runs at half
	assign bitRise = dmclkTick && (sclkCnt_ff == 3'h0);
	// at /2 the half point rounds to the rise tick, so the fall takes the second tick
	assign bitFall = dmclkTick && (sclkCnt_ff == ((sclkLast == `SCLK_LAST_2) ? `SCLK_LAST_2
		: (sclkLast >> 1)));
	assign sampleTick = dmclkTick && (srCnt_ff == 12'h000);

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mcdCnt_ff <= 3'h0;
			dmclkTick <= 1'b0;
			sclkCnt_ff <= 3'h0;
			srCnt_ff <= 12'h000;
			sclkOut <= 1'b0;
		end
		else if (ce)
		begin
			dmclkTick <= (mcdCnt_ff >= mcdLast);
			mcdCnt_ff <= (mcdCnt_ff >= mcdLast) ? 3'h0 : mcdCnt_ff + 3'h1;
			if (dmclkTick)
			begin
				sclkCnt_ff <= (sclkCnt_ff >= sclkLast) ? 3'h0 : sclkCnt_ff + 3'h1;
				srCnt_ff <= (srCnt_ff >= srLast) ? 12'h000 : srCnt_ff + 12'h001;
			end
			if (bitRise && (sclkLast != `SCLK_LAST_1))
				sclkOut <= 1'b1;
			else if (bitFall)
				sclkOut <= ~sclkOut & (sclkLast == `SCLK_LAST_1);
		end
	end

	// ************************************************************
	// shared shift register and frame sequencing
	// ************************************************************
	reg  [15:0] shift_ff;
	reg  [3:0]  bitCnt_ff;
	reg         busy_ff;
	reg         hostSent_ff;
	reg         pendEvent_ff;
	reg         respValid_ff;
	reg  [15:0] resp_ff;
	reg         wordDone;
	wire [15:0] rxWord;
	wire        isCtl;
	wire [2:0]  devAddr;
	wire [3:0]  regIdx;
	wire        fifoInReady;
	wire        fifoInValid;
	wire [16:0] fifoOut;
	wire        fifoOutValid;

	// the last bit lands on this rise, so take it straight from the synchroniser
	assign rxWord = {shift_ff[14:0], sdiVal_ff};
	assign isCtl = opMode ? (mixedMode & rxWord[`WORD_CTL_BIT])
		: rxWord[`WORD_CTL_BIT];
	assign devAddr = rxWord[`WORD_DEV_HI:`WORD_DEV_LO];
	assign regIdx = {devAddr[0], rxWord[`WORD_REG_HI:`WORD_REG_LO]};
	// writes and samples queue; reads and forwards answer straight away
	assign fifoInValid = wordDone && hostSent_ff &&
		(isCtl ? (devAddr < `DEVS_PER_PART) && !rxWord[`WORD_RW_BIT] : opMode);
	// nothing can stall the host, so a full queue drops the word
	assign rxOverflow = fifoInValid && !fifoInReady;

	always @*
	begin
		wordDone = busy_ff && bitRise && (bitCnt_ff == `WORD_LAST_BIT);
	end

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			shift_ff <= 16'h0000;
			bitCnt_ff <= 4'h0;
			busy_ff <= 1'b0;
			hostSent_ff <= 1'b0;
			pendEvent_ff <= 1'b0;
			respValid_ff <= 1'b0;
			resp_ff <= 16'h0000;
			outFrameSync <= 1'b0;
			sdoOut <= 1'b0;
			sampleEvent <= 1'b0;
		end
		else if (ce)
		begin
			sampleEvent <= 1'b0;
			if (sampleTick)
				pendEvent_ff <= 1'b1;
			if (bitRise && busy_ff)
			begin
				shift_ff <= {shift_ff[14:0], sdiVal_ff};
				bitCnt_ff <= bitCnt_ff + 4'h1;
				if (fsVal_ff)
					hostSent_ff <= 1'b1;
				if (bitCnt_ff == `WORD_LAST_BIT)
					busy_ff <= 1'b0;
			end
			else if (bitRise && fsVal_ff && !pendEvent_ff && !respValid_ff)
			begin
				busy_ff <= 1'b1; // host word outside an output frame
				hostSent_ff <= 1'b1;
				bitCnt_ff <= 4'h1;
				shift_ff <= {shift_ff[14:0], sdiVal_ff};
			end
			if (wordDone && hostSent_ff && isCtl && !opMode || wordDone && hostSent_ff
				&& isCtl && mixedMode)
			begin
				if (devAddr >= `DEVS_PER_PART)
				begin
					resp_ff <= {rxWord[15:14], devAddr - `DEVS_PER_PART,
						rxWord[`WORD_REG_HI:0]};
					respValid_ff <= 1'b1;
				end
				else if (rxWord[`WORD_RW_BIT])
				begin
					resp_ff <= {rxWord[15:8], ctlRegs[regIdx]};
					respValid_ff <= 1'b1;
				end
			end
			// frames start on the falling edge so data is stable at the rise
			if (bitFall)
			begin
				if (!busy_ff && (pendEvent_ff || respValid_ff))
				begin
					shift_ff <= pendEvent_ff ? adcSample : resp_ff;
					sdoOut <= pendEvent_ff ? adcSample[15] : resp_ff[15];
					sampleEvent <= pendEvent_ff;
					if (pendEvent_ff)
						pendEvent_ff <= sampleTick;
					else
						respValid_ff <= 1'b0;
					outFrameSync <= 1'b1;
					busy_ff <= 1'b1;
					hostSent_ff <= 1'b0;
					bitCnt_ff <= 4'h0;
				end
				else
				begin
					outFrameSync <= 1'b0;
					sdoOut <= shift_ff[15];
				end
			end
		end
	end

	// ************************************************************
	// queue consumer: register writes and converter output samples
	// ************************************************************
	reg        dacSel_ff;
	reg  [1:0] dtapUpperSeen_ff;
	reg  [1:0] dtapLowerSeen_ff;
	reg  [31:0] dtapValue_ff;
	wire       popNow;
	wire       popCtl;
	wire [3:0] popIdx;
	wire [15:0] popSample;
	integer    i;

	word_fifo #(
		.WIDTH     (17),
		.DEPTH_LOG (`FIFO_DEPTH_LOG)
	) rxQueue (
		.clk      (clk),
		.reset_n  (reset_n),
		.ce       (ce),
		.inData   ({isCtl, rxWord}),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.outData  (fifoOut),
		.outValid (fifoOutValid),
		.outReady (bitFall)
	);

	assign popNow = fifoOutValid && bitFall;
	assign popCtl = fifoOut[16];
	assign popIdx = {fifoOut[`WORD_DEV_LO], fifoOut[`WORD_REG_HI:`WORD_REG_LO]};
	assign popSample = mixedMode ? {fifoOut[14:0], 1'b0} : fifoOut[15:0];

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (i = 0; i < 16; i = i + 1)
				ctlRegs[i] <= `REG_RESET_VALUE;
			dacSel_ff <= 1'b0;
			dacSample <= 32'h00000000;
			dtapUpperSeen_ff <= 2'h0;
			dtapLowerSeen_ff <= 2'h0;
			dtapValue_ff <= 32'h00000000;
		end
		else if (ce)
		begin
			// clear first so that a tap byte written in the same cycle is kept
			for (i = 0; i < 2; i = i + 1)
			begin
				if (dtapUpperSeen_ff[i] && dtapLowerSeen_ff[i])
				begin
					dtapValue_ff[i*16 +: 16] <= {ctlRegs[i*8 + `REG_DTAP_UPPER],
						ctlRegs[i*8 + `REG_DTAP_LOWER]};
					dtapUpperSeen_ff[i] <= 1'b0;
					dtapLowerSeen_ff[i] <= 1'b0;
				end
			end
			if (sampleEvent)
				dacSel_ff <= 1'b0;
			if (popNow && popCtl)
			begin
				ctlRegs[popIdx] <= fifoOut[`WORD_DATA_HI:`WORD_DATA_LO];
				if (popIdx[2:0] == `REG_DTAP_UPPER)
					dtapUpperSeen_ff[popIdx[3]] <= 1'b1;
				if (popIdx[2:0] == `REG_DTAP_LOWER)
					dtapLowerSeen_ff[popIdx[3]] <= 1'b1;
			end
			else if (popNow)
			begin
				// first sample of a period feeds channel one, the next channel two
				if (dacSel_ff)
					dacSample[31:16] <= popSample;
				else
					dacSample[15:0] <= popSample;
				dacSel_ff <= ~dacSel_ff;
			end
		end
	end

	// ************************************************************
	// gain taps, one copy per channel
	// ************************************************************
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1)
		begin : tapChan
			wire [7:0] powerReg;
			wire [7:0] atapReg;
			wire [4:0] coef;
			wire [5:0] rawGain;
			wire [15:0] dtap;
			wire [15:0] interp;

			assign powerReg = ctlRegs[ch*8 + `REG_POWER];
			assign atapReg = ctlRegs[ch*8 + `REG_ANALOG_TAP];
			assign coef = atapReg[`ATAP_COEF_HI:`ATAP_COEF_LO];
			// gain in sixteenths, twos complement; no code gives zero
			assign rawGain = coef[`ATAP_SIGN_BIT] ? (`ATAP_NEG_BASE - {1'b0, coef})
				: (`ATAP_UNITY - {1'b0, coef});
			assign analogTapPowered[ch] = powerReg[`PWR_ATAP_BIT];
			assign analogTapConnect[ch] = powerReg[`PWR_ATAP_BIT] &
				atapReg[`ATAP_EN_BIT];
			assign analogTapGain[ch*6 +: 6] = (powerReg[`PWR_ATAP_BIT] &&
				!atapReg[`ATAP_MUTE_BIT]) ? rawGain : 6'h00;
			assign dtap = dtapValue_ff[ch*16 +: 16];
			assign interp = interpOut[ch*16 +: 16];

			always @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
					tapSum[ch*17 +: 17] <= 17'h00000;
				else if (ce && dmclkTick)
					tapSum[ch*17 +: 17] <= modBit[ch]
						? {interp[15], interp} + {dtap[15], dtap}
						: {interp[15], interp} - {dtap[15], dtap};
			end
		end
	endgenerate
endmodule // codec_serial_port

// [tb/codec_serial_port_sva.sv]
// assertion checker for the codec serial port top level
`timescale 1ns/1ns
module codec_serial_port_chk (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        sclkOut,
	input wire logic        outFrameSync,
	input wire logic        sdoOut,
	input wire logic        dmclkTick,
	input wire logic        sampleEvent,
	input wire logic [33:0] tapSum,
	input wire logic [11:0] analogTapGain,
	input wire logic [1:0]  analogTapConnect,
	input wire logic [1:0]  analogTapPowered
);
// ****************************************************************
// link framing and tap configuration
// ****************************************************************
default clocking @(posedge clk);
endclocking
default disable iff (!reset_n);
property p_fs_after_se;
	sampleEvent |-> ##[0:80] $rose(outFrameSync);
endproperty
a_fs_after_se: assert property (p_fs_after_se) else $error("no frame after sample");
property p_fs_edge;
	$changed(outFrameSync) |-> $fell(sclkOut);
endproperty
a_fs_edge: assert property (p_fs_edge) else $error("frame sync off falling edge");
// frame sync must drop within two bits even at the slowest clocks
property p_fs_len;
	$rose(outFrameSync) |-> ##[1:80] $fell(outFrameSync);
endproperty
a_fs_len: assert property (p_fs_len) else $error("frame sync too long");
property p_sdo_edge;
	$changed(sdoOut) |-> $fell(sclkOut);
endproperty
a_sdo_edge: assert property (p_sdo_edge) else $error("data off falling edge");
property p_se_pulse;
	sampleEvent |=> !sampleEvent;
endproperty
a_se_pulse: assert property (p_se_pulse) else $error("sample event too long");
property p_gain_off;
	!analogTapPowered[0] |-> analogTapGain[5:0] == 6'h00;
endproperty
a_gain_off: assert property (p_gain_off) else $error("gain while unpowered");
property p_conn_pwr;
	analogTapConnect[1] |-> analogTapPowered[1];
endproperty
a_conn_pwr: assert property (p_conn_pwr) else $error("tap connected unpowered");
property p_tap_tick;
	$changed(tapSum) |-> dmclkTick || $past(dmclkTick);
endproperty
a_tap_tick: assert property (p_tap_tick) else $error("tap sum off device tick");
endmodule // codec_serial_port_chk
bind codec_serial_port codec_serial_port_chk u_chk (.clk, .reset_n, .sclkOut, .outFrameSync,
	.sdoOut, .dmclkTick, .sampleEvent, .tapSum, .analogTapGain, .analogTapConnect,
	.analogTapPowered);

// [tb/host_serial_model.sv]
// host serial port model, slave on the codec link
`timescale 1ns/1ns
module host_serial_model (
	input  wire logic sclkOut,
	input  wire logic outFrameSync,
	input  wire logic sdoOut,
	output logic      sdiIn,
	output logic      inFrameSyncIn
);
// ****************************************************************
// receive and transmit shifters
// ****************************************************************
logic [15:0] txQ [$];
logic [15:0] rxQ [$];
logic [15:0] txSh;
logic [15:0] rxSh;
int          txCnt = 0;
int          rxCnt = 0;
initial
begin
	sdiIn = 1'b0;
	inFrameSyncIn = 1'b0;
end
always @(posedge sclkOut)
begin
	if (outFrameSync)
	begin
		rxCnt = 1;
		rxSh = {15'h0000, sdoOut};
	end
	else if (rxCnt != 0)
	begin
		rxSh = {rxSh[14:0], sdoOut};
		rxCnt++;
	end
	if (rxCnt == 16)
	begin
		rxQ.push_back(rxSh);
		rxCnt = 0;
	end
end
// a word goes out only once the device has opened a frame, one per frame
always @(negedge sclkOut)
begin
	#1;
	if (txCnt == 0 && outFrameSync && txQ.size() != 0)
	begin
		txSh = txQ.pop_front();
		txCnt = 16;
	end
	inFrameSyncIn = (txCnt == 16);
	if (txCnt != 0)
	begin
		sdiIn = txSh[15];
		txSh = txSh << 1;
		txCnt--;
	end
	else
		sdiIn = ~sdiIn; // idle line toggles, so no stale value
end
endmodule // host_serial_model

// [tb/test_codec_serial_port.sv]
// self-checking bench for the codec serial port and gain taps
`timescale 1ns/1ns
`include "codec_consts.vh"
module test_codec_serial_port;
logic        clk, reset_n, ce, sclkOut, outFrameSync, sdoOut, sdiIn, inFrameSyncIn;
logic        dmclkTick, sampleEvent, rxOverflow;
logic [1:0]  modBit, analogTapConnect, analogTapPowered;
logic [11:0] analogTapGain;
logic [15:0] adcSample, w, v, t;
logic [31:0] interpOut, dacSample;
logic [33:0] tapSum;
logic [4:0]  cs [6];
logic [4:0]  c;
logic        ovfSeen = 1'b0;
int          error_cnt = 0;
int          n_compared = 0;
int          i, j, n;
codec_serial_port u_dut (.clk, .reset_n, .ce, .sclkOut, .outFrameSync, .sdoOut, .sdiIn,
	.inFrameSyncIn, .adcSample, .modBit, .interpOut, .dacSample, .tapSum, .analogTapGain,
	.analogTapConnect, .analogTapPowered, .dmclkTick, .sampleEvent, .rxOverflow);
host_serial_model u_host (.sclkOut, .outFrameSync, .sdoOut, .sdiIn, .inFrameSyncIn);
// ****************************************************************
// expectations and link tasks
// ****************************************************************
function logic [5:0] agExp(input logic [4:0] k);
	return (k < 5'h10) ? 6'h10 - {1'b0, k} : 6'h0F - {1'b0, k};
endfunction
function int mdiv(input int k);
	return (k >= 1 && k <= 4) ? k + 1 : 1;
endfunction
function logic [16:0] tapExp(input logic m, input logic [15:0] a, input logic [15:0] b);
	return m ? {a[15], a} + {b[15], b} : {a[15], a} - {b[15], b};
endfunction
function logic sg(input int s);
	return (s == 1) ? sclkOut : sampleEvent;
endfunction
task check(input logic [33:0] seen, input logic [33:0] exp);
	n_compared++;
	if (seen !== exp)
	begin
		error_cnt++;
		$display("Error at %0t: saw %h expected %h", $time, seen, exp);
	end
endtask
task report_and_stop;
	$display("compared %0d errors %0d", n_compared, error_cnt);
	if (error_cnt == 0 && n_compared > 0)
		$display("All checks passed");
	else
		$display("Checks failed");
	$finish;
endtask
task fail;
	error_cnt++;
	$display("Error at %0t: wait ran out", $time);
	report_and_stop();
endtask
// the apply wait covers two bits at the slowest clock settings used
task send(input logic [15:0] x);
	int k;
	u_host.txQ.push_back(x);
	k = 0;
	while ((u_host.txQ.size() != 0 || u_host.txCnt != 0) && k < 40000)
	begin
		@(negedge clk);
		k++;
	end
	if (k == 40000)
		fail();
	repeat (80) @(negedge clk);
endtask
task wr(input logic [2:0] ch, input logic [2:0] r, input logic [7:0] x);
	send({2'b10, ch, r, x});
endtask
task cfg(input logic [7:0] x);
	wr(3'h1, `REG_CLOCK_DIV, x);
	wr(3'h0, `REG_CLOCK_DIV, x);
endtask
task find(input logic [7:0] hi, output logic [15:0] x);
	int k;
	for (k = 0; k < 6000; k++)
	begin
		@(negedge clk);
		while (u_host.rxQ.size() != 0)
		begin
			x = u_host.rxQ.pop_front();
			if (x[15:8] === hi)
				return;
		end
	end
	fail();
endtask
task rd(input logic [2:0] ch, input logic [2:0] r, input logic [7:0] x);
	u_host.rxQ.delete();
	send({2'b11, ch, r, 8'h00});
	find({2'b11, ch, r}, v);
	check(v, {2'b11, ch, r, x});
endtask
task gap(input int s, output int m);
	int e;
	logic p;
	e = 0;
	m = 0;
	p = sg(s);
	while (e < 2 && m < 20000)
	begin
		@(posedge clk);
		#1;
		m++;
		if (sg(s) && !p)
		begin
			e++;
			if (e == 1)
				m = 0;
		end
		p = sg(s);
	end
	if (e < 2)
		fail();
endtask
initial
begin
	clk = 1'b0;
	forever #5 clk = ~clk;
end
// a dropped word is only a one-clock pulse, so keep it sticky
always @(negedge clk)
begin
	if (reset_n && rxOverflow !== 1'b0)
		ovfSeen = 1'b1;
end
initial
begin
	reset_n = 1'b0;
	ce = 1'b1;
	adcSample = 16'h0000;
	modBit = 2'h0;
	interpOut = 32'h00000000;
	cs = '{5'h00, 5'h01, 5'h0F, 5'h10, 5'h1E, 5'h1F};
	void'($urandom(92806));
	repeat (8) @(negedge clk);
	reset_n = 1'b1;
	check(dacSample, 0);
	check(tapSum, 0);
	check(analogTapGain, 0);
	for (i = 0; i < 8; i++)
	begin
		cfg({1'b0, i[2:0], 4'h3});
		gap(1, n);
		check(n, 8 * mdiv(i));
		gap(2, n);
		check(n, 256 * mdiv(i));
	end
	for (i = 1; i < 3; i++)
	begin
		cfg({4'h4, i[1:0], 2'h3});
		gap(1, n);
		check(n, 5 * (8 >> i));
	end
	for (i = 0; i < 3; i++)
	begin
		cfg({6'h00, i[1:0]});
		gap(2, n);
		check(n, 2048 >> i);
	end
	cfg(8'h13);
	for (i = 2; i < 8; i++)
	begin
		rd(3'h1, i[2:0], 8'h00);
		rd(3'h0, i[2:0], 8'h00);
		w = $urandom;
		wr(3'h0, i[2:0], w[7:0]);
		rd(3'h0, i[2:0], w[7:0]);
	end
	wr(3'h0, `REG_POWER, 8'h02);
	for (i = 0; i < 6; i++)
	begin
		wr(3'h0, `REG_ANALOG_TAP, {3'b001, cs[i]});
		check(analogTapGain[5:0], agExp(cs[i]));
		check(analogTapConnect[0], 1'b1);
	end
	c = $urandom;
	wr(3'h0, `REG_ANALOG_TAP, {3'b101, c});
	check(analogTapGain[5:0], 6'h00);
	wr(3'h0, `REG_ANALOG_TAP, {3'b000, c});
	check(analogTapConnect[0], 1'b0);
	wr(3'h0, `REG_POWER, 8'h00);
	check(analogTapGain[5:0], 6'h00);
	wr(3'h1, `REG_POWER, 8'h02);
	wr(3'h1, `REG_ANALOG_TAP, {3'b001, 5'h10});
	check(analogTapGain[11:6], 6'h3F);
	check(analogTapPowered, 2'h2);
	interpOut = {16'($urandom), 16'($urandom)};
	for (i = 0; i < 3; i++)
	begin
		t = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7FFF : 16'($urandom);
		wr(3'h0, `REG_DTAP_UPPER, t[15:8]);
		wr(3'h0, `REG_DTAP_LOWER, t[7:0]);
		for (j = 0; j < 2; j++)
		begin
			modBit = j[1:0];
			repeat (4) @(negedge clk);
			check(tapSum[16:0], tapExp(j[0], interpOut[15:0], t));
			check(tapSum[33:17], tapExp(1'b0, interpOut[31:16], 16'h0000));
		end
	end
	wr(3'h0, `REG_DTAP_UPPER, 8'h00);
	check(tapSum[16:0], tapExp(1'b1, interpOut[15:0], t));
	ce = 1'b0;
	interpOut[15:0] = ~interpOut[15:0];
	repeat (4) @(negedge clk);
	check(tapSum[16:0], tapExp(1'b1, ~interpOut[15:0], t));
	ce = 1'b1;
	u_host.rxQ.delete();
	w = {2'b10, 3'h3, 3'h5, 8'($urandom)};
	send(w);
	find({2'b10, 3'h1, 3'h5}, v);
	check(v, w - 16'h1000);
	adcSample = {8'h01, 8'($urandom)};
	u_host.rxQ.delete();
	find(8'h01, v);
	check(v, adcSample);
	wr(3'h1, `REG_SERIAL_MODE, 8'h03);
	wr(3'h0, `REG_SERIAL_MODE, 8'h03);
	w = {1'b0, 15'($urandom)};
	send(w);
	check(dacSample[15:0], {w[14:0], 1'b0});
	wr(3'h0, `REG_POWER, 8'h02);
	check(analogTapPowered[0], 1'b1);
	wr(3'h1, `REG_SERIAL_MODE, 8'h01);
	wr(3'h0, `REG_SERIAL_MODE, 8'h01);
	w = {1'b1, 15'($urandom)};
	send(w);
	check(dacSample[15:0], w);
	check(ovfSeen, 1'b0);
	report_and_stop();
end
endmodule // test_codec_serial_port
